// [spi_nv_sram_slave_port_bench.sv]
// Bench: host and device joined by the link interface.
// Drives the host command port; inputs change 1 ns after the edge.
`timescale 1ns/1ps
module spi_nv_sram_slave_port_bench;
    import spi_nvs_pkg::*;
    logic              ref_clk_i = 1'h0;
    logic              rst_i = 1'h0;
    logic              hold = 1'h0;
    logic              pf = 1'h0;
    logic              pin = 1'h0;
    logic              vld = 1'h0;
    logic              wp = 1'h0;
    logic              sreq = 1'h0;
    logic              seen = 1'h0;
    logic [7:0]        op = 8'h00;
    logic [7:0]        wd = 8'h00;
    logic [ADDR_W-1:0] ad = '0;
    logic [7:0]        rd;
    logic              rdy, rv, busy, nvb;
    int                num_errors = 0;
    int                tests_run = 0;
    spi_nvs_if link_if ();
    spi_nvs_device u_spi_nvs_device (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link_if),
        .power_fail_i(pf), .nv_busy_o(nvb));
    spi_nvs_host u_spi_nvs_host (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .link(link_if),
        .cmd_valid_i(vld), .cmd_ready_o(rdy), .cmd_op_i(op), .cmd_addr_i(ad),
        .cmd_wdata_i(wd), .rsp_valid_o(rv), .rsp_data_o(rd), .hold_req_i(hold),
        .wp_req_i(wp), .save_req_i(sreq), .busy_o(busy));
    spi_nvs_assertions u_spi_nvs_assertions (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
        .cs_n(link_if.cs_n), .sck(link_if.sck), .si(link_if.si), .so(link_if.so),
        .so_oe(link_if.so_oe), .dev_busy_out(link_if.dev_busy_out),
        .dev_busy_oe(link_if.dev_busy_oe));
    always #25 ref_clk_i = ~ref_clk_i;
    // Sticky so a short busy pulse is not missed between polls
    always @(posedge ref_clk_i) if (nvb === 1'h1) seen <= 1'h1;
    always @(posedge ref_clk_i) if (busy === 1'h1) pin <= 1'h1;
    task automatic final_report();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic wait_for(ref logic s, input logic lvl);
        int n;
        n = 0;
        while (s !== lvl) begin
            tick(1);
            n++;
            if (n > 2000) begin
                $display("MISMATCH t=%0t wait timed out", $time);
                num_errors++;
                final_report();
            end
        end
    endtask
    task automatic cmd(input logic [7:0] o, input logic [ADDR_W-1:0] a, input logic [7:0] w);
        wait_for(rdy, 1'h1);
        vld = 1'h1;
        op = o;
        ad = a;
        wd = w;
        tick(1);
        vld = 1'h0;
        wait_for(rv, 1'h1);
    endtask
    task automatic wr_rd(input logic [ADDR_W-1:0] a, input logic [7:0] w, input logic [7:0] e);
        cmd(OP_WRITE, a, w);
        cmd(OP_READ, a, 8'h00);
        check(rd, e);
    endtask
    task automatic t_status();
        cmd(OP_RDSR, '0, 8'h00);
        check(rd, 8'h40);
        cmd(OP_PLS_OFF, '0, 8'h00);
        cmd(OP_RDSR, '0, 8'h00);
        check(rd, 8'h00);
        cmd(OP_PLS_ON, '0, 8'h00);
        cmd(OP_WREN, '0, 8'h00);
        cmd(OP_RDSR, '0, 8'h00);
        check(rd, 8'h42);
    endtask
    task automatic t_protect();
        wr_rd(17'h1FFFF, 8'hA5, 8'hA5);
        wr_rd(17'h18000, 8'h3C, 8'h3C);
        wr_rd(17'h17FFF, 8'hC3, 8'hC3);
        wp = 1'h1;
        wr_rd(17'h17FFF, 8'h11, 8'hC3);
        wp = 1'h0;
        cmd(OP_WRITE_DISABLE_CMD, '0, 8'h00);
        wr_rd(17'h17FFF, 8'h22, 8'hC3);
        cmd(OP_WREN, '0, 8'h00);
        cmd(OP_WRSR, '0, 8'h44);
        wr_rd(17'h18000, 8'h77, 8'h3C);
        wr_rd(17'h17FFF, 8'h77, 8'h77);
        cmd(OP_WRSR, '0, 8'h4C);
        wr_rd(17'h17FFF, 8'h55, 8'h77);
        cmd(OP_WRSR, '0, 8'h40);
    endtask
    task automatic nv_op(input logic [7:0] o);
        seen = 1'h0;
        pin = 1'h0;
        cmd(o, '0, 8'h00);
        wait_for(nvb, 1'h0);
        check({7'h00, seen}, 8'h01);
        check({7'h00, pin}, 8'h01);
    endtask
    task automatic hw_save(input logic e, input logic pf_path);
        pf   = pf_path;
        sreq = ~pf_path;
        tick(20);
        pf   = 1'h0;
        sreq = 1'h0;
        tick(6);
        seen = 1'h0;
        tick(10);
        check({7'h00, seen}, {7'h00, e});
        wait_for(nvb, 1'h0);
    endtask
    // Line held low by the host: accesses refused, status shows busy
    task automatic t_busy();
        sreq = 1'h1;
        tick(8);
        check({7'h00, busy}, 8'h01);
        cmd(OP_RDSR, '0, 8'h00);
        check(rd, 8'h43);
        cmd(OP_WRITE, 17'h00010, 8'h00);
        cmd(OP_READ, 17'h00010, 8'h00);
        check(rd, 8'hFF);
        sreq = 1'h0;
        wait_for(nvb, 1'h0);
        check({7'h00, busy}, 8'h00);
        cmd(OP_READ, 17'h00010, 8'h00);
        check(rd, 8'h9A);
    endtask
    task automatic t_hold();
        fork
            cmd(OP_READ, 17'h00010, 8'h00);
            begin
                tick(120);
                hold = 1'h1;
                tick(40);
                hold = 1'h0;
            end
        join
        check(rd, 8'h9A);
    endtask
    initial begin
        #1;
        rst_i = 1'h1;
        tick(4);
        rst_i = 1'h0;
        t_status();
        t_protect();
        nv_op(OP_SAVE);
        nv_op(OP_SAVE);
        nv_op(OP_RESTORE);
        hw_save(1'h0, 1'h0);
        wr_rd(17'h00010, 8'h9A, 8'h9A);
        hw_save(1'h1, 1'h0);
        t_busy();
        t_hold();
        wr_rd(17'h00020, 8'h5A, 8'h5A);
        hw_save(1'h1, 1'h1);
        hw_save(1'h0, 1'h1);
        final_report();
    end
endmodule

// [spi_nvs_assertions.sv]
// Link checks for the serial memory port.
// Sees the interface wires only; sck is a slow copy of ref_clk_i.
`timescale 1ns/1ps
module spi_nvs_assertions (
    input wire logic ref_clk_i,
    input wire logic rst_i,
    input wire logic cs_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic dev_busy_out,
    input wire logic dev_busy_oe
);
    logic pull;
    assign pull = dev_busy_oe & ~dev_busy_out;
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (rst_i);
    property p_so_idle; cs_n |-> !so_oe; endproperty
    a_so_idle: assert property (p_so_idle)
        else $error("so driven outside frame");
    property p_sck_idle; cs_n |-> !sck; endproperty
    a_sck_idle: assert property (p_sck_idle)
        else $error("sck moved outside frame");
    property p_si_hold; $rose(sck) |-> $stable(si); endproperty
    a_si_hold: assert property (p_si_hold)
        else $error("si moved at sample edge");
    property p_so_fall; !cs_n && $changed(so) |-> $fell(sck); endproperty
    a_so_fall: assert property (p_so_fall)
        else $error("so changed off falling edge");
    property p_oe_fall; $rose(so_oe) |-> $fell(sck); endproperty
    a_oe_fall: assert property (p_oe_fall)
        else $error("so enabled off falling edge");
    property p_busy_span; $rose(pull) |-> pull[*8] ##[1:300] !pull; endproperty
    a_busy_span: assert property (p_busy_span)
        else $error("busy low span wrong");
    property p_hi_after; $rose(dev_busy_out) && dev_busy_oe |-> $past(pull); endproperty
    a_hi_after: assert property (p_hi_after)
        else $error("high drive without busy");
    property p_hi_brief; $rose(dev_busy_out) && dev_busy_oe |-> ##[1:3] !dev_busy_oe;
    endproperty
    a_hi_brief: assert property (p_hi_brief)
        else $error("busy line not released");
    c_read: cover property ($rose(so_oe));
    c_busy: cover property ($rose(pull));
    c_high: cover property ($rose(dev_busy_out) && dev_busy_oe);
endmodule

// [spi_nvs_device.sv]
// Serial slave port of a 128K x 8 nonvolatile SRAM.
// Link logic runs on the serial clock; the save/restore engine on ref_clk_i.
// Assumes the host holds si, cs_n, hold_n and wp_n steady around rising edges.
`timescale 1ns/1ps
module spi_nvs_device #(
    parameter bit HAS_WP       = 1'b1,
    parameter bit HAS_BUSY_PIN = 1'b1,
    parameter bit HAS_PLS      = 1'b1
) (
    input  wire logic   ref_clk_i,
    input  wire logic   rst_i,
    spi_nvs_if.dev      link,
    input  wire logic   power_fail_i,
    output logic        nv_busy_o
);
    import spi_nvs_pkg::*;

    typedef enum logic [2:0] {F_OP, F_ADDR, F_WR, F_RD, F_WRSR, F_RDSR, F_SKIP} fph_t;
    typedef enum logic [1:0] {NV_IDLE, NV_DELAY, NV_BUSY, NV_HIGH} nv_t;

    typedef struct packed {
        fph_t              ph;
        logic [4:0]        cnt;
        logic [23:0]       sh;
        logic [ADDR_W-1:0] addr;
        logic [7:0]        rd;
        logic              is_rd;
    } frame_t;

    typedef struct packed {
        logic       wel;
        logic [1:0] bp;
        logic       pls_en;
        logic       dirty;
        logic       save_t;
        logic       rest_t;
        logic [1:0] busy_s;
        logic [1:0] clr_s;
        logic       clr_seen;
    } keep_t;

    typedef struct packed {
        logic so;
        logic oe;
    } out_t;

    typedef struct packed {
        nv_t              st;
        logic [CNT_W-1:0] cnt;
        logic [1:0]       save_s;
        logic [1:0]       rest_s;
        logic [1:0]       dirty_s;
        logic [1:0]       pf_s;
        logic [1:0]       line_s;
        logic [1:0]       pls_s;
        logic             save_seen;
        logic             rest_seen;
        logic             clean;
        logic             is_save;
        logic             clr_t;
        logic             busy;
        logic             pin_oe;
        logic             pin_out;
    } nv_reg_t;

    frame_t  fq, fd;
    keep_t   kq, kd;
    out_t    oq, od;
    nv_reg_t nq, nd;

    logic [7:0]        mem [MEM_DEPTH];
    logic              we;
    logic [ADDR_W-1:0] wa;
    logic [7:0]        wdat;
    logic              frame_rst;
    logic              busy;
    logic              wp_on;
    logic [7:0]        byte_in;
    logic [ADDR_W-1:0] addr_in;
    logic [ADDR_W-1:0] addr_nx;

    function automatic logic is_protected(input logic [ADDR_W-1:0] a, input logic [1:0] bp);
        unique case (bp)
            2'h0: is_protected = 1'b0;
            2'h1: is_protected = (a[16:15] == 2'h3);
            2'h2: is_protected = a[16];
            2'h3: is_protected = 1'b1;
        endcase
    endfunction

    function automatic logic [7:0] status_byte(input keep_t k, input logic b);
        status_byte                      = 8'h00;
        status_byte[ST_BUSY_BIT]         = b;
        status_byte[ST_WEL_BIT]          = k.wel;
        status_byte[ST_BP_LSB +: 2]      = k.bp;
        status_byte[ST_PLS_BIT]          = k.pls_en & HAS_PLS;
    endfunction

    // Chip select high holds all frame state in reset
    assign frame_rst = rst_i | link.cs_n;
    assign busy      = kq.busy_s[1];
    assign wp_on     = HAS_WP & ~link.wp_n;
    assign byte_in   = {fq.sh[6:0], link.si};
    assign addr_in   = {fq.sh[15:0], link.si};
    assign addr_nx   = fq.addr + ADDR_W'(1);

    always_comb begin
        fd   = fq;
        kd   = kq;
        we   = 1'b0;
        wa   = fq.addr;
        wdat = byte_in;
        kd.busy_s = {kq.busy_s[0], nq.busy};
        kd.clr_s  = {kq.clr_s[0], nq.clr_t};
        if (kq.clr_s[1] != kq.clr_seen) begin
            kd.clr_seen = kq.clr_s[1];
            kd.dirty    = 1'b0;
        end
        // Hold freezes every frame field in place
        if (!link.cs_n && link.hold_n) begin
            fd.sh  = {fq.sh[22:0], link.si};
            fd.cnt = fq.cnt + 5'h01;
            unique case (fq.ph)
                F_OP: if (fq.cnt == 5'h07) begin
                    fd.cnt = 5'h00;
                    fd.ph  = F_SKIP;
                    case (byte_in)
                        OP_READ: if (!busy) begin
                            fd.ph    = F_ADDR;
                            fd.is_rd = 1'b1;
                        end
                        OP_WRITE: if (!busy) begin
                            fd.ph    = F_ADDR;
                            fd.is_rd = 1'b0;
                        end
                        OP_RDSR: begin
                            fd.ph = F_RDSR;
                            fd.rd = status_byte(kq, busy);
                        end
                        OP_WRSR:    fd.ph = F_WRSR;
                        OP_WREN:    kd.wel = 1'b1;
                        OP_WRITE_DISABLE_CMD:    kd.wel = 1'b0;
                        OP_SAVE:    if (!busy) kd.save_t = ~kq.save_t;
                        OP_RESTORE: if (!busy) kd.rest_t = ~kq.rest_t;
                        OP_PLS_ON:  kd.pls_en = HAS_PLS;
                        OP_PLS_OFF: kd.pls_en = 1'b0;
                        default:    fd.ph = F_SKIP;
                    endcase
                end
                F_ADDR: if (fq.cnt == 5'h17) begin
                    fd.cnt  = 5'h00;
                    fd.addr = addr_in;
                    if (fq.is_rd) begin
                        fd.ph = F_RD;
                        fd.rd = mem[addr_in];
                    end else begin
                        fd.ph = F_WR;
                    end
                end
                F_WR: if (fq.cnt == 5'h07) begin
                    fd.cnt  = 5'h00;
                    fd.addr = addr_nx;
                    // Save may start mid-burst, so busy is checked per byte
                    if (kq.wel && !wp_on && !busy
                            && !is_protected(fq.addr, kq.bp)) begin
                        we       = 1'b1;
                        kd.dirty = 1'b1;
                    end
                end
                F_RD: if (fq.cnt == 5'h07) begin
                    fd.cnt  = 5'h00;
                    fd.addr = addr_nx;
                    fd.rd   = busy ? 8'h00 : mem[addr_nx];
                end
                F_WRSR: if (fq.cnt == 5'h07) begin
                    fd.ph = F_SKIP;
                    if (kq.wel && !wp_on) begin
                        kd.bp = byte_in[ST_BP_LSB +: 2];
                    end
                end
                F_RDSR: if (fq.cnt == 5'h07) begin
                    fd.cnt = 5'h00;
                    fd.rd  = status_byte(kq, busy);
                end
                F_SKIP: fd.cnt = 5'h00;
            endcase
        end
    end

    // Output bit changes on the falling edge; hold_n drops the enable only at a falling edge, and sck parks high in hold
    always_comb begin
        od.so = fq.rd[~fq.cnt[2:0]];
        od.oe = ((fq.ph == F_RD) || (fq.ph == F_RDSR)) && link.hold_n;
    end

    always_ff @(posedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            fq <= '{ph: F_OP, default: '0};
        end else begin
            fq <= fd;
        end
    end

    always_ff @(posedge link.sck or posedge rst_i) begin
        if (rst_i) begin
            kq <= '{bp: BP_RST, pls_en: PLS_EN_RST & HAS_PLS, default: '0};
        end else begin
            kq <= kd;
        end
    end

    always_ff @(negedge link.sck or posedge frame_rst) begin
        if (frame_rst) begin
            oq <= '0;
        end else begin
            oq <= od;
        end
    end

    // Array write at the last data bit's rising edge
    always_ff @(posedge link.sck) begin
        if (we) begin
            mem[wa] <= wdat;
        end
    end

    // Save/restore engine on the reference clock
    always_comb begin
        nd         = nq;
        nd.save_s  = {nq.save_s[0], kq.save_t};
        nd.rest_s  = {nq.rest_s[0], kq.rest_t};
        nd.dirty_s = {nq.dirty_s[0], kq.dirty};
        nd.pf_s    = {nq.pf_s[0], power_fail_i};
        nd.line_s  = {nq.line_s[0], link.busy_line};
        nd.pls_s   = {nq.pls_s[0], kq.pls_en};
        // Link clock may stop after a save, so the dirty copy can lag;
        // clean masks it until the link side acknowledges the clear
        if (!nq.dirty_s[1]) begin
            nd.clean = 1'b0;
        end
        nd.cnt = nq.cnt - CNT_W'(1);
        unique case (nq.st)
            NV_IDLE: begin
                nd.cnt = nq.cnt;
                if (nq.save_s[1] != nq.save_seen) begin
                    nd.save_seen = nq.save_s[1];
                    nd.st        = NV_BUSY;
                    nd.cnt       = SAVE_CYC;
                    nd.is_save   = 1'b1;
                    nd.clr_t     = ~nq.clr_t;
                    nd.clean     = 1'b1;
                end else if (nq.rest_s[1] != nq.rest_seen) begin
                    nd.rest_seen = nq.rest_s[1];
                    nd.st        = NV_BUSY;
                    nd.cnt       = RESTORE_CYC;
                    nd.is_save   = 1'b0;
                    nd.clr_t     = ~nq.clr_t;
                    nd.clean     = 1'b1;
                end else if (((HAS_BUSY_PIN && !nq.line_s[1])
                        || (HAS_PLS && nq.pls_s[1] && nq.pf_s[1]))
                        && nq.dirty_s[1] && !nq.clean) begin
                    nd.st  = NV_DELAY;
                    nd.cnt = HW_DELAY_CYC;
                end
            end
            NV_DELAY: if (nq.cnt == CNT_W'(1)) begin
                nd.st      = NV_BUSY;
                nd.cnt     = SAVE_CYC;
                nd.is_save = 1'b1;
                nd.clr_t   = ~nq.clr_t;
                nd.clean   = 1'b1;
            end
            NV_BUSY: if (nq.cnt == CNT_W'(1)) begin
                nd.st  = nq.is_save ? NV_HIGH : NV_IDLE;
                nd.cnt = DRIVE_HIGH_CYC;
            end
            NV_HIGH: if (nq.cnt == CNT_W'(1)) begin
                nd.st = NV_IDLE;
            end
        endcase
        // A held-low line also keeps accesses off
        nd.busy    = (nd.st == NV_BUSY) || (nd.st == NV_DELAY)
                     || (HAS_BUSY_PIN && !nq.line_s[1]);
        nd.pin_oe  = HAS_BUSY_PIN && ((nd.st == NV_BUSY) || (nd.st == NV_HIGH));
        nd.pin_out = (nd.st == NV_HIGH);
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            nq <= '{st: NV_IDLE, line_s: 2'h3, default: '0};
        end else begin
            nq <= nd;
        end
    end

    assign link.so           = oq.so;
    assign link.so_oe        = oq.oe;
    assign link.dev_busy_out = nq.pin_out;
    assign link.dev_busy_oe  = nq.pin_oe;
    assign nv_busy_o         = nq.busy;

endmodule

// [spi_nvs_host.sv]
// Host end of the serial memory link: one command per frame, mode 0.
// Makes the serial clock by dividing ref_clk_i by eight.
`timescale 1ns/1ps
module spi_nvs_host (
    input  wire logic                       ref_clk_i,
    input  wire logic                       rst_i,
    spi_nvs_if.host                         link,
    input  wire logic                       cmd_valid_i,
    output logic                            cmd_ready_o,
    input  wire logic [7:0]                 cmd_op_i,
    input  wire logic [spi_nvs_pkg::ADDR_W-1:0] cmd_addr_i,
    input  wire logic [7:0]                 cmd_wdata_i,
    output logic                            rsp_valid_o,
    output logic [7:0]                      rsp_data_o,
    input  wire logic                       hold_req_i,
    input  wire logic                       wp_req_i,
    input  wire logic                       save_req_i,
    output logic                            busy_o
);
    import spi_nvs_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} hst_t;

    typedef struct packed {
        hst_t        st;
        logic [2:0]  ph;
        logic [5:0]  nbits;
        logic [39:0] sh;
        logic [7:0]  rx;
        logic        cs_n;
        logic        sck;
        logic        si;
        logic        hold_n;
        logic        wp_n;
        logic        hsb_oe;
        logic        ready;
        logic        rsp_valid;
        logic [7:0]  rsp_data;
        logic [1:0]  so_s;
        logic [1:0]  line_s;
    } host_t;

    host_t q, d;

    // Opcode, three address bytes, data for array access
    function automatic logic [45:0] frame_of(input logic [7:0] op,
                                             input logic [ADDR_W-1:0] a,
                                             input logic [7:0] w);
        if (op == OP_READ || op == OP_WRITE) begin
            frame_of = {6'h28, op, 7'h00, a, w};
        end else if (op == OP_RDSR || op == OP_WRSR) begin
            frame_of = {6'h10, op, w, 24'h000000};
        end else begin
            frame_of = {6'h08, op, 32'h00000000};
        end
    endfunction

    always_comb begin
        d           = q;
        d.rsp_valid = 1'b0;
        d.so_s      = {q.so_s[0], link.so_line};
        d.line_s    = {q.line_s[0], link.busy_line};
        d.wp_n      = ~wp_req_i;
        d.hsb_oe    = save_req_i;
        unique case (q.st)
            H_IDLE: begin
                d.ready = 1'b1;
                if (cmd_valid_i) begin
                    {d.nbits, d.sh} = frame_of(cmd_op_i, cmd_addr_i, cmd_wdata_i);
                    d.si    = d.sh[39];
                    d.sh    = {d.sh[38:0], 1'b0};
                    d.cs_n  = 1'b0;
                    d.ready = 1'b0;
                    d.ph    = 3'h1;
                    d.st    = H_RUN;
                end
            end
            H_RUN: begin
                d.ph = q.ph + 3'h1;
                if (q.ph == 3'h0) begin
                    // Clock parks high in hold; release costs one cycle so
                    // hold_n is settled before the next falling edge
                    d.hold_n = ~hold_req_i;
                    if (hold_req_i || !q.hold_n) begin
                        d.ph = q.ph;
                    end else begin
                        d.sck = 1'b0;
                        d.si  = q.sh[39];
                        d.sh  = {q.sh[38:0], 1'b0};
                    end
                end
                if (q.ph == PH_RISE) begin
                    d.sck = 1'b1;
                end
                if (q.ph == PH_SAMPLE) begin
                    d.rx    = {q.rx[6:0], q.so_s[1]};
                    d.nbits = q.nbits - 6'h01;
                    if (q.nbits == 6'h01) begin
                        d.st = H_GAP;
                    end
                end
            end
            H_GAP: begin
                d.sck = 1'b0;
                d.ph  = q.ph + 3'h1;
                if (q.ph == 3'h3) begin
                    d.cs_n      = 1'b1;
                    d.rsp_valid = 1'b1;
                    d.rsp_data  = q.rx;
                end
                if (q.ph == PH_SAMPLE) begin
                    d.st    = H_IDLE;
                    d.ready = 1'b1;
                end
            end
            default: d.st = H_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q <= '{st: H_IDLE, cs_n: 1'b1, hold_n: 1'b1, wp_n: 1'b1,
                   so_s: 2'h3, line_s: 2'h3, default: '0};
        end else begin
            q <= d;
        end
    end

    assign link.cs_n          = q.cs_n;
    assign link.sck           = q.sck;
    assign link.si            = q.si;
    assign link.hold_n        = q.hold_n;
    assign link.wp_n          = q.wp_n;
    assign link.host_busy_out = 1'b0;
    assign link.host_busy_oe  = q.hsb_oe;
    assign cmd_ready_o        = q.ready;
    assign rsp_valid_o        = q.rsp_valid;
    assign rsp_data_o         = q.rsp_data;
    assign busy_o             = ~q.line_s[1];

endmodule

// [spi_nvs_if.sv]
// Link between the serial memory port and its host.
// Resolves the open-drain busy line (weak pull-up) and the data-out line.
`timescale 1ns/1ps
interface spi_nvs_if;
    logic cs_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic hold_n;
    logic wp_n;
    logic dev_busy_out;
    logic dev_busy_oe;
    logic host_busy_out;
    logic host_busy_oe;
    logic so_line;
    logic busy_line;

    // Undriven lines float high through the pull-ups
    assign so_line   = so_oe ? so : 1'b1;
    assign busy_line = ~((dev_busy_oe & ~dev_busy_out) | (host_busy_oe & ~host_busy_out));

    modport dev (
        input  cs_n, sck, si, hold_n, wp_n, busy_line,
        output so, so_oe, dev_busy_out, dev_busy_oe
    );
    modport host (
        output cs_n, sck, si, hold_n, wp_n, host_busy_out, host_busy_oe,
        input  so_line, busy_line
    );
endinterface

// [spi_nvs_pkg.sv]
// Shared constants for the serial nonvolatile SRAM port and its host.
// Assumes a 20 MHz reference clock at both ends.
package spi_nvs_pkg;

    // Array geometry
    localparam int ADDR_W    = 17;
    localparam int MEM_DEPTH = 131072;

    // Instruction codes
    localparam logic [7:0] OP_WRSR     = 8'h01;
    localparam logic [7:0] OP_WRITE    = 8'h02;
    localparam logic [7:0] OP_READ     = 8'h03;
    localparam logic [7:0] OP_WRITE_DISABLE_CMD     = 8'h04;
    localparam logic [7:0] OP_RDSR     = 8'h05;
    localparam logic [7:0] OP_WREN     = 8'h06;
    localparam logic [7:0] OP_SAVE     = 8'h3C;
    localparam logic [7:0] OP_RESTORE  = 8'h60;
    localparam logic [7:0] OP_PLS_ON   = 8'h59;
    localparam logic [7:0] OP_PLS_OFF  = 8'h19;

    // Status byte layout and reset values
    localparam int         ST_BUSY_BIT = 0;
    localparam int         ST_WEL_BIT  = 1;
    localparam int         ST_BP_LSB   = 2;
    localparam int         ST_PLS_BIT  = 6;
    localparam logic [1:0] BP_RST      = 2'h0;
    localparam logic       PLS_EN_RST  = 1'b1;

    // Timing, reference clock cycles rounded up
    localparam int REF_PERIOD_NS   = 50;
    localparam int SAVE_TIME_NS    = 2000;
    localparam int RESTORE_TIME_NS = 1000;
    localparam int DRIVE_HIGH_NS   = 100;
    localparam int HW_DELAY_NS     = 100;
    localparam int CNT_W           = 8;
    localparam logic [CNT_W-1:0] SAVE_CYC =
        CNT_W'((SAVE_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
    localparam logic [CNT_W-1:0] RESTORE_CYC =
        CNT_W'((RESTORE_TIME_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
    localparam logic [CNT_W-1:0] DRIVE_HIGH_CYC =
        CNT_W'((DRIVE_HIGH_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);
    localparam logic [CNT_W-1:0] HW_DELAY_CYC =
        CNT_W'((HW_DELAY_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS);

    // Host serial clock: eight reference cycles per bit, 2.5 MHz
    localparam int         SCK_MAX_HZ = 40000000;
    localparam logic [2:0] PH_RISE    = 3'h4;
    localparam logic [2:0] PH_SAMPLE  = 3'h7;

endpackage
